// ===== shared/comd_pkg.sv
// constants, types and field layouts for the chirp mixer decimator
//
// How it works
// (RULE_01) up chirp: start at minimum, subtract from phase
// (RULE_02) up chirp: add delta to increment low bits
// (RULE_03) up chirp: at or past maximum, reload minimum
// (RULE_04) down chirp: start maximum increment, offset phase
// (RULE_05) down chirp: subtract delta from increment
// (RULE_06) down chirp: below minimum, reload maximum
// (RULE_07) up/down: rise from minimum toward maximum
// (RULE_08) up/down: fall to minimum, restart rising
// (RULE_09) minimum and maximum increments are 32 bits
// (RULE_10) delta increment is a 24-bit field
// (RULE_11) quadrature cos and negated sin, scaled down
// (RULE_12) phase word to generator is 18 bits
// (RULE_13) mixer products symmetrically rounded to 17 bits
// (RULE_14) two five-stage cascaded decimators, I and Q
// (RULE_15) shifter positions input by programmed amount
// (RULE_16) reset clears decimators, no output until refilled
// (RULE_17) output rate clock over R, preload R-1
// (RULE_18) first clock after reset loads phase offset
// (RULE_19) 33-bit phase register, increment subtracted
// (RULE_20) constant tone uses minimum increment only
// (RULE_21) mode field picks one of four modes
package comd_pkg;
   // ---------------------------------------------------------------
   // register map (byte addresses)
   // ---------------------------------------------------------------
   localparam logic [7:0] ADDR_CTRL   = 8'h00;
   localparam logic [7:0] ADDR_OFFSET = 8'h04;
   localparam logic [7:0] ADDR_MININC = 8'h08;
   localparam logic [7:0] ADDR_MAXINC = 8'h0c;
   localparam logic [7:0] ADDR_DELTA  = 8'h10;
   localparam logic [7:0] ADDR_STATUS = 8'h14;
   // ---------------------------------------------------------------
   // field layout of the control register
   // ---------------------------------------------------------------
   localparam int MODE_LSB    = 0;   // two bits
   localparam int OFFBIN_BIT  = 2;   // input is offset binary
   localparam int SHIFT_LSB   = 8;   // seven bits
   localparam int PRELOAD_LSB = 16;  // fifteen bits
   // ---------------------------------------------------------------
   // widths
   // ---------------------------------------------------------------
   localparam int INC_W    = 32;
   localparam int DELTA_W  = 24;
   localparam int PHASE_W  = 33;
   localparam int PWORD_W  = 18;
   localparam int SAMPLE_W = 16;
   localparam int MIX_W    = 17;
   localparam int SHIFT_W  = 7;
   localparam int PRE_W    = 15;
   localparam int STAGES   = 5;
   localparam int ACC_W    = 92;   // mixer width plus largest growth
   localparam int OUT_W    = 18;
   localparam int CORD_N   = 16;
   localparam int CORD_W   = 20;
   // ---------------------------------------------------------------
   // constants
   // ---------------------------------------------------------------
   localparam logic [CORD_W-1:0] CORD_START = 20'h049d6;
   localparam logic [31:0] ROUND_POS = 32'h00004000;
   localparam logic [31:0] ROUND_NEG = 32'h00003fff;
   localparam logic [31:0] CTRL_RESET = 32'h00000000;
   // arctangent of 2^-i, one full turn is 2^18
   localparam logic [17:0] ATAN [CORD_N] = '{
      18'h08000, 18'h04b90, 18'h027ed, 18'h01444, 18'h00a2c,
      18'h00517, 18'h0028c, 18'h00146, 18'h000a3, 18'h00051,
      18'h00029, 18'h00014, 18'h0000a, 18'h00005, 18'h00003,
      18'h00001};
   // ---------------------------------------------------------------
   // types
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      MODE_TONE, MODE_UP, MODE_DOWN, MODE_UPDOWN
   } comd_mode_type;
   typedef struct packed {
      logic signed [MIX_W-1:0] i;
      logic signed [MIX_W-1:0] q;
   } comd_iq_type;
endpackage

// ===== rtl/comd_cascade_decimator.sv
// five-stage cascaded integrator comb decimator with input shifter
`timescale 1ns/10ps
`default_nettype none
module comd_cascade_decimator
(
   input  wire logic                              clk,     // system clock
   input  wire logic                              sys_rst, // async reset
   input  wire logic signed [comd_pkg::MIX_W-1:0] dataIn,  // mixer sample
   input  wire logic [comd_pkg::SHIFT_W-1:0]      shift,   // left shift
   input  wire logic [comd_pkg::PRE_W-1:0]        preload, // R minus one
   output logic signed [comd_pkg::OUT_W-1:0]      dataOut, // decimated
   output logic                                   valid    // output pulse
);
   logic signed [comd_pkg::ACC_W-1:0] integ [comd_pkg::STAGES+1];
   logic signed [comd_pkg::ACC_W-1:0] comb  [comd_pkg::STAGES+1];
   logic signed [comd_pkg::ACC_W-1:0] delay [comd_pkg::STAGES];
   logic [comd_pkg::PRE_W-1:0]        count;
   logic [2:0]                        fill;
   logic                              tick;
   // ---------------------------------------------------------------
   // shifter and integrators
   // ---------------------------------------------------------------
   // RULE_15 data shifter
   assign integ[0] = comd_pkg::ACC_W'(dataIn) <<< shift;
   assign tick = (count == '0);
   assign comb[0] = integ[comd_pkg::STAGES];
   genvar s;
   generate
      for (s = 0; s < comd_pkg::STAGES; s++)
      begin : g_stage
         // RULE_14 integrator stage
         always_ff @(posedge clk or posedge sys_rst)
         begin
            if (sys_rst)
               integ[s+1] <= '0;
            else
               integ[s+1] <= integ[s+1] + integ[s];
         end
         // comb stage at decimated rate
         always_ff @(posedge clk or posedge sys_rst)
         begin
            if (sys_rst)
               delay[s] <= '0;
            else if (tick)
               delay[s] <= comb[s];
         end
         assign comb[s+1] = comb[s] - delay[s];
      end
   endgenerate
   // RULE_17 decimation counter
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         count <= '0;
      else if (tick)
         count <= preload;
      else
         count <= count - 1'b1;
   end
   // RULE_16 hold output until refilled
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         fill <= '0;
      else if (tick && fill != 3'(comd_pkg::STAGES))
         fill <= fill + 1'b1;
   end
   // output register, top bits of the last comb stage
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         dataOut <= '0;
         valid   <= 1'b0;
      end
      else
      begin
         valid <= tick && fill == 3'(comd_pkg::STAGES);
         if (tick)
            dataOut <= comb[comd_pkg::STAGES]
                       [comd_pkg::ACC_W-1 -: comd_pkg::OUT_W];
      end
   end
endmodule // comd_cascade_decimator
`default_nettype wire

// ===== rtl/comd_chirp_mixer.sv
// chirp phase generator, sine/cosine, mixer and decimators with apb
`timescale 1ns/10ps
`default_nettype none
module comd_chirp_mixer
(
   input  wire logic                                clk,     // 20 MHz
   input  wire logic                                sys_rst, // async
   input  wire logic [7:0]                          paddr,   // apb addr
   input  wire logic                                psel,    // apb sel
   input  wire logic                                penable, // apb en
   input  wire logic                                pwrite,  // apb dir
   input  wire logic [31:0]                         pwdata,  // apb wdata
   output logic [31:0]                              prdata,  // apb rdata
   output logic                                     pready,  // apb ready
   output logic                                     pslverr, // apb error
   input  wire logic [comd_pkg::SAMPLE_W-1:0]       adcData, // sample in
   output logic signed [comd_pkg::OUT_W-1:0]        iOut,    // I result
   output logic signed [comd_pkg::OUT_W-1:0]        qOut,    // Q result
   output logic                                     outValid // pulse
);
   // ---------------------------------------------------------------
   // declarations
   // ---------------------------------------------------------------
   logic [31:0]                      ctrl;
   logic [comd_pkg::PWORD_W-1:0]     phaseOffset;
   logic [comd_pkg::INC_W-1:0]       minInc;
   logic [comd_pkg::INC_W-1:0]       maxInc;
   logic [comd_pkg::DELTA_W-1:0]     deltaInc;
   logic [comd_pkg::PHASE_W-1:0]     phase;
   logic [comd_pkg::INC_W-1:0]       inc;
   logic                             falling;
   logic                             restart;
   logic [comd_pkg::INC_W:0]         incUp;
   logic [comd_pkg::INC_W:0]         incDown;
   logic [comd_pkg::INC_W-1:0]       next_inc;
   logic                             next_falling;
   logic [comd_pkg::PWORD_W-1:0]     phaseWord;
   logic signed [15:0]               cosVal;
   logic signed [15:0]               sinNeg;
   logic signed [comd_pkg::SAMPLE_W-1:0] sample;
   comd_pkg::comd_iq_type            mixed;
   comd_pkg::comd_mode_type          mode;
   logic                             apbAccess;
   logic signed [comd_pkg::OUT_W-1:0] iDec;
   logic signed [comd_pkg::OUT_W-1:0] qDec;
   logic                             iValid;
   logic                             qValid;

   // RULE_21 mode field
   assign mode = comd_pkg::comd_mode_type'(ctrl[comd_pkg::MODE_LSB +: 2]);
   assign apbAccess = psel && penable && !pready;

   // ---------------------------------------------------------------
   // apb register writes
   // ---------------------------------------------------------------
   // RULE_09 and RULE_10 parameter fields
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         ctrl        <= comd_pkg::CTRL_RESET;
         phaseOffset <= '0;
         minInc      <= '0;
         maxInc      <= '0;
         deltaInc    <= '0;
      end
      else if (apbAccess && pwrite)
      begin
         if (paddr == comd_pkg::ADDR_CTRL)
            ctrl <= pwdata;
         else if (paddr == comd_pkg::ADDR_OFFSET)
            phaseOffset <= pwdata[comd_pkg::PWORD_W-1:0];
         else if (paddr == comd_pkg::ADDR_MININC)
            minInc <= pwdata;
         else if (paddr == comd_pkg::ADDR_MAXINC)
            maxInc <= pwdata;
         else if (paddr == comd_pkg::ADDR_DELTA)
            deltaInc <= pwdata[comd_pkg::DELTA_W-1:0];
      end
   end

   // ---------------------------------------------------------------
   // apb answer, one wait state on every access
   // ---------------------------------------------------------------
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= '0;
      end
      else
      begin
         pready  <= apbAccess;
         pslverr <= 1'b0;
         prdata  <= '0;
         if (apbAccess)
         begin
            if (paddr == comd_pkg::ADDR_CTRL)
               prdata <= ctrl;
            else if (paddr == comd_pkg::ADDR_OFFSET)
               prdata <= 32'(phaseOffset);
            else if (paddr == comd_pkg::ADDR_MININC)
               prdata <= minInc;
            else if (paddr == comd_pkg::ADDR_MAXINC)
               prdata <= maxInc;
            else if (paddr == comd_pkg::ADDR_DELTA)
               prdata <= 32'(deltaInc);
            else if (paddr == comd_pkg::ADDR_STATUS && !pwrite)
               prdata <= {falling, 13'h0000, phaseWord};
            else
               pslverr <= 1'b1;
         end
      end
   end

   // ---------------------------------------------------------------
   // restart request: reset release or a control write
   // ---------------------------------------------------------------
   // RULE_18 start after reset release
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         restart <= 1'b1;
      else
         restart <= apbAccess && pwrite && paddr == comd_pkg::ADDR_CTRL;
   end

   // ---------------------------------------------------------------
   // next increment candidates
   // ---------------------------------------------------------------
   // RULE_02 add delta to increment
   assign incUp = {1'b0, inc} + {9'h000, deltaInc};
   // RULE_05 subtract delta from increment
   assign incDown = {1'b0, inc} - {9'h000, deltaInc};

   // increment sequencing per mode
   always_comb
   begin
      next_inc     = inc;
      next_falling = falling;
      case (mode)
         comd_pkg::MODE_TONE:
         begin
            // RULE_20 tone uses minimum only
            next_inc     = minInc;
            next_falling = 1'b0;
         end
         comd_pkg::MODE_UP:
         begin
            // RULE_03 reload minimum at maximum
            if (incUp >= {1'b0, maxInc})
               next_inc = minInc;
            else
               next_inc = incUp[comd_pkg::INC_W-1:0];
         end
         comd_pkg::MODE_DOWN:
         begin
            // RULE_06 reload maximum below minimum
            if (incDown[comd_pkg::INC_W] || incDown < {1'b0, minInc})
               next_inc = maxInc;
            else
               next_inc = incDown[comd_pkg::INC_W-1:0];
         end
         default:
         begin
            if (!falling)
            begin
               // RULE_07 rising half
               if (incUp >= {1'b0, maxInc})
               begin
                  next_falling = 1'b1;
                  next_inc     = incDown[comd_pkg::INC_W-1:0];
               end
               else
                  next_inc = incUp[comd_pkg::INC_W-1:0];
            end
            else
            begin
               // RULE_08 back to minimum, rise again
               if (incDown[comd_pkg::INC_W] || incDown <= {1'b0, minInc})
               begin
                  next_falling = 1'b0;
                  next_inc     = minInc;
               end
               else
                  next_inc = incDown[comd_pkg::INC_W-1:0];
            end
         end
      endcase
   end

   // ---------------------------------------------------------------
   // increment register
   // ---------------------------------------------------------------
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         inc     <= '0;
         falling <= 1'b0;
      end
      else if (restart)
      begin
         falling <= 1'b0;
         // RULE_04 down chirp starts at maximum
         if (mode == comd_pkg::MODE_DOWN)
            inc <= maxInc;
         else
            // RULE_01 start at minimum
            inc <= minInc;
      end
      else
      begin
         inc     <= next_inc;
         falling <= next_falling;
      end
   end

   // ---------------------------------------------------------------
   // phase register
   // ---------------------------------------------------------------
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         phase <= '0;
      else if (restart)
         // RULE_18 load offset into top bits
         phase <= {phaseOffset, 15'h0000};
      else
         // RULE_19 subtract increment, wrapping over a full turn
         phase <= phase - {1'b0, inc};
   end

   // RULE_12 eighteen-bit phase word
   assign phaseWord = phase[comd_pkg::PHASE_W-1 -: comd_pkg::PWORD_W];

   // ---------------------------------------------------------------
   // sine/cosine by rotation over the first quadrant
   // ---------------------------------------------------------------
   // RULE_11 quadrature generator
   always_ff @(posedge clk or posedge sys_rst)
   begin : p_sincos
      logic signed [comd_pkg::CORD_W-1:0] x;
      logic signed [comd_pkg::CORD_W-1:0] y;
      logic signed [comd_pkg::CORD_W-1:0] xt;
      logic signed [18:0]                 z;
      if (sys_rst)
      begin
         cosVal <= '0;
         sinNeg <= '0;
      end
      else
      begin
         x = comd_pkg::CORD_START;
         y = '0;
         z = {3'b000, phaseWord[15:0]};
         for (int k = 0; k < comd_pkg::CORD_N; k++)
         begin
            xt = x;
            if (z >= 0)
            begin
               x = x - (y >>> k);
               y = y + (xt >>> k);
               z = z - $signed({1'b0, comd_pkg::ATAN[k]});
            end
            else
            begin
               x = x + (y >>> k);
               y = y - (xt >>> k);
               z = z + $signed({1'b0, comd_pkg::ATAN[k]});
            end
         end
         // quadrant fold, sine output negated
         case (phaseWord[17:16])
            2'b00:
            begin
               cosVal <= x[15:0];
               sinNeg <= -y[15:0];
            end
            2'b01:
            begin
               cosVal <= -y[15:0];
               sinNeg <= -x[15:0];
            end
            2'b10:
            begin
               cosVal <= -x[15:0];
               sinNeg <= y[15:0];
            end
            default:
            begin
               cosVal <= y[15:0];
               sinNeg <= x[15:0];
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // mixer with symmetric rounding
   // ---------------------------------------------------------------
   assign sample = ctrl[comd_pkg::OFFBIN_BIT]
                 ? $signed({~adcData[15], adcData[14:0]})
                 : $signed(adcData);

   // RULE_13 multiply and round to 17 bits
   always_ff @(posedge clk or posedge sys_rst)
   begin : p_mix
      logic signed [31:0] pi;
      logic signed [31:0] pq;
      if (sys_rst)
         mixed <= '0;
      else
      begin
         pi = sample * cosVal;
         pq = sample * sinNeg;
         pi = pi + (pi[31] ? comd_pkg::ROUND_NEG : comd_pkg::ROUND_POS);
         pq = pq + (pq[31] ? comd_pkg::ROUND_NEG : comd_pkg::ROUND_POS);
         mixed.i <= pi[31 -: comd_pkg::MIX_W];
         mixed.q <= pq[31 -: comd_pkg::MIX_W];
      end
   end

   // ---------------------------------------------------------------
   // decimators for I and Q
   // ---------------------------------------------------------------
   // RULE_14 I branch
   comd_cascade_decimator u_dec_i
   (
      .clk     (clk),
      .sys_rst (sys_rst),
      .dataIn  (mixed.i),
      .shift   (ctrl[comd_pkg::SHIFT_LSB +: comd_pkg::SHIFT_W]),
      .preload (ctrl[comd_pkg::PRELOAD_LSB +: comd_pkg::PRE_W]),
      .dataOut (iDec),
      .valid   (iValid)
   );
   // RULE_14 Q branch
   comd_cascade_decimator u_dec_q
   (
      .clk     (clk),
      .sys_rst (sys_rst),
      .dataIn  (mixed.q),
      .shift   (ctrl[comd_pkg::SHIFT_LSB +: comd_pkg::SHIFT_W]),
      .preload (ctrl[comd_pkg::PRELOAD_LSB +: comd_pkg::PRE_W]),
      .dataOut (qDec),
      .valid   (qValid)
   );

   // ---------------------------------------------------------------
   // output registers
   // ---------------------------------------------------------------
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         iOut     <= '0;
         qOut     <= '0;
         outValid <= 1'b0;
      end
      else
      begin
         outValid <= iValid && qValid;
         if (iValid && qValid)
         begin
            iOut <= iDec;
            qOut <= qDec;
         end
      end
   end
endmodule // comd_chirp_mixer
`default_nettype wire

// ===== verification/comd_chirp_mixer_props.sv
// port checker for the chirp mixer decimator
`timescale 1ns/10ps
`default_nettype none
module comd_chirp_mixer_props
(
   input wire logic        clk,     // clock
   input wire logic        sys_rst, // reset
   input wire logic [7:0]  paddr,   // address
   input wire logic        psel,    // select
   input wire logic        penable, // enable
   input wire logic        pwrite,  // direction
   input wire logic [31:0] prdata,  // read data
   input wire logic        pready,  // ready
   input wire logic        pslverr, // error
   input wire logic signed [comd_pkg::OUT_W-1:0] iOut, // I
   input wire logic signed [comd_pkg::OUT_W-1:0] qOut, // Q
   input wire logic        outValid // strobe
);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   logic [15:0] gap;  // cycles since last strobe
   logic [2:0]  seen; // strobes since control write, 7 idle
   logic        bad;  // access to a refused place
   assign bad = paddr > comd_pkg::ADDR_STATUS || paddr[1:0] != 2'b00
      || (pwrite && paddr == comd_pkg::ADDR_STATUS);
   // strobe spacing, restarted by any control write
   always_ff @(posedge clk or posedge sys_rst)
      if (sys_rst)
      begin
         gap <= '0;
         seen <= '1;
      end
      else
      begin
         gap <= outValid ? 16'h0000 : gap + 16'h0001;
         if (psel && pwrite && paddr == comd_pkg::ADDR_CTRL)
            seen <= '0;
         else if (outValid && seen < 3'd4)
            seen <= seen + 3'd1;
      end
   sequence apbWait;
      psel && penable && !pready;
   endsequence
   sequence apbDone;
      psel && penable && pready;
   endsequence
   chk_ready_wait: assert property (apbWait |=> pready)
      else $error("pready late");
   chk_ready_alone: assert property (pready |-> psel && penable)
      else $error("pready outside access");
   chk_ready_pulse: assert property (pready |=> !pready)
      else $error("pready too long");
   chk_slave_err: assert property (apbDone |-> pslverr == bad)
      else $error("pslverr wrong");
   chk_rdata_idle: assert property (!pready |-> prdata == 32'h00000000)
      else $error("prdata not idle");
   chk_out_hold: assert property (!outValid |-> $stable(iOut) && $stable(qOut))
      else $error("output moved without strobe");
   chk_rate_exact: assert property (outValid && seen == 3'd4 |-> gap == 16'h0003)
      else $error("strobe spacing wrong");
   chk_reset_quiet: assert property ($fell(sys_rst) |-> !outValid [*5])
      else $error("output soon after reset");
endmodule // comd_chirp_mixer_props
bind comd_chirp_mixer comd_chirp_mixer_props i_props (.clk(clk),
   .sys_rst(sys_rst), .paddr(paddr), .psel(psel), .penable(penable),
   .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .iOut(iOut), .qOut(qOut), .outValid(outValid));
`default_nettype wire

// ===== verification/comd_adc_model.sv
// converter model feeding samples to the mixer
`timescale 1ns/10ps
`default_nettype none
module comd_adc_model
(
   input  wire logic        clk,   // sample clock
   input  wire logic [15:0] level, // wanted value
   output logic      [15:0] sample // converted sample
);
   // new conversion lands just after each rising edge
   always_ff @(posedge clk)
      sample <= level;
endmodule // comd_adc_model
`default_nettype wire

// ===== verification/tb.sv
// self-checking bench for the chirp mixer decimator
`timescale 1ns/10ps
`default_nettype none
module tb;
   typedef struct {
      logic [1:0] mode; logic [31:0] mn, mx; logic [23:0] dl;
      logic c1; logic [17:0] d1, dd;
   } comd_row_type;
   localparam logic [31:0] CTRL_R4 = 32'h00034100; // R 4, shift 65
   logic clk, sys_rst, psel, penable, pwrite, pready, pslverr, outValid;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [15:0] level, adcData;
   logic signed [17:0] iOut, qOut;
   logic [17:0] pw [3];
   logic [17:0] d1, d2;
   logic err, lastHi;
   int fails, compares, cyc, n, hi, tg;
   comd_row_type rows [5] = '{
      '{2'd0, 32'h10000, 32'h8000, 24'h8000, 1'b1, 18'h8, 18'h0},
      '{2'd1, 32'h8000, 32'h28000, 24'h8000, 1'b1, 18'ha, 18'h0},
      '{2'd2, 32'h10000, 32'h28000, 24'h8000, 1'b1, 18'he, 18'h0},
      '{2'd1, 32'h0, 32'hffffffff, 24'h800000, 1'b0, 18'h0, 18'h01000},
      '{2'd2, 32'h0, 32'hf0000000, 24'h8000, 1'b0, 18'h0, 18'h3fff0}};
   comd_adc_model i_adc (.clk(clk), .level(level), .sample(adcData));
   comd_chirp_mixer i_dut (.clk(clk), .sys_rst(sys_rst), .paddr(paddr),
      .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .adcData(adcData), .iOut(iOut), .qOut(qOut), .outValid(outValid));
   // clock and hang guard
   initial
   begin
      clk = 0;
      forever #25 clk = ~clk;
   end
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         fails++;
         report_and_stop();
      end
   end
   task automatic check_word(input string nm, input logic [31:0] e, g);
      compares++;
      if (g !== e)
      begin
         fails++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic check_flag(input string nm, input logic g);
      check_word(nm, 32'h1, {31'h0, g});
   endtask
   // one apb transfer, held until pready is sampled high
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge clk);
      psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge clk);
      penable <= 1;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (pready !== 1'b1);
      rd = prdata; err = pslverr;
      psel <= 0; penable <= 0;
   endtask
   task automatic wait_valid();
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (outValid !== 1'b1);
   endtask
   // tone mixing, sign of each channel then strobe spacing
   task automatic mix(input logic [17:0] off, input logic [15:0] lv,
                      input logic ob, input int ei, eq);
      level <= lv;
      apb(1, comd_pkg::ADDR_OFFSET, {14'h0, off});
      apb(1, comd_pkg::ADDR_MININC, 32'h0);
      apb(1, comd_pkg::ADDR_CTRL, CTRL_R4 | {29'h0, ob, 2'b00});
      repeat (12) wait_valid();
      check_flag("iSign", ei > 0 ? iOut > 18'sh04000 : ei < 0 ? iOut <
         -18'sh04000 : iOut < 18'sh00400 && iOut > -18'sh00400);
      check_flag("qSign", eq > 0 ? qOut > 18'sh04000 : eq < 0 ? qOut <
         -18'sh04000 : qOut < 18'sh00400 && qOut > -18'sh00400);
      wait_valid();
      check_word("gap", 32'h4, n);
   endtask
   task automatic report_and_stop();
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // main sequence
   initial
   begin
      sys_rst = 1; psel = 0; penable = 0; pwrite = 0; paddr = '0;
      pwdata = '0; level = '0; fails = 0; compares = 0;
      repeat (5) @(posedge clk);
      sys_rst <= 0;
      apb(0, comd_pkg::ADDR_CTRL, 0);
      check_word("ctrlReset", comd_pkg::CTRL_RESET, rd);
      apb(0, 8'h18, 0);
      check_word("unmapped", 32'h80000000, {err, rd[30:0]});
      apb(1, comd_pkg::ADDR_STATUS, 32'h5);
      check_flag("roWrite", err);
      apb(1, comd_pkg::ADDR_MAXINC, 32'hfedcba98);
      apb(0, comd_pkg::ADDR_MAXINC, 0);
      check_word("maxBack", 32'hfedcba98, rd);
      for (int k = 0; k < 5; k++)
      begin
         apb(1, comd_pkg::ADDR_OFFSET, 0);
         apb(1, comd_pkg::ADDR_MININC, rows[k].mn);
         apb(1, comd_pkg::ADDR_MAXINC, rows[k].mx);
         apb(1, comd_pkg::ADDR_DELTA, {8'h0, rows[k].dl});
         apb(1, comd_pkg::ADDR_CTRL, CTRL_R4 | {30'h0, rows[k].mode});
         for (int j = 0; j < 3; j++)
         begin
            apb(0, comd_pkg::ADDR_STATUS, 0);
            pw[j] = rd[17:0];
         end
         d1 = pw[0] - pw[1];
         d2 = pw[1] - pw[2] - d1;
         if (rows[k].c1)
            check_word("step", {14'h0, rows[k].d1}, {14'h0, d1});
         check_word("stepGrowth", {14'h0, rows[k].dd}, {14'h0, d2});
      end
      apb(1, comd_pkg::ADDR_OFFSET, 32'h2a5a5);
      apb(1, comd_pkg::ADDR_MININC, 0);
      apb(1, comd_pkg::ADDR_CTRL, CTRL_R4);
      apb(0, comd_pkg::ADDR_STATUS, 0);
      check_word("offsetLoad", 32'h0002a5a5, rd);
      apb(1, comd_pkg::ADDR_MININC, 32'h8000);
      apb(1, comd_pkg::ADDR_MAXINC, 32'h100000);
      apb(1, comd_pkg::ADDR_DELTA, 32'h8000);
      apb(1, comd_pkg::ADDR_CTRL, CTRL_R4 | 32'h3);
      hi = 0; tg = 0; lastHi = 0;
      for (int j = 0; j < 40; j++)
      begin
         apb(0, comd_pkg::ADDR_STATUS, 0);
         hi += rd[31];
         tg += (rd[31] != lastHi);
         lastHi = rd[31];
      end
      check_flag("bothHalves", hi > 0 && hi < 40);
      check_flag("restart", tg >= 3);
      mix(18'h0, 16'h4000, 1'b0, 1, 0);
      mix(18'h10000, 16'h4000, 1'b0, 0, -1);
      mix(18'h0, 16'h4000, 1'b1, -1, 0);
      sys_rst <= 1;
      repeat (5) @(posedge clk);
      sys_rst <= 0;
      repeat (3)
      begin
         @(posedge clk);
         check_word("quiet", 32'h0, {outValid, iOut});
      end
      report_and_stop();
   end
endmodule // tb
`default_nettype wire
